// File: logic/dmacc_defs.svh
// constants for the dma channel control block
// How it works
// R1: completion with interrupt enable set raises the interrupt request output
// R2: variable byte length: eighth-bit mode picks 8 or 7 low length bits
// R3: priority 00: cpu access always goes first, dma waits
// R4: priority 01: dma wins over cpu at least every second attempt
// R5: priority 10: dma always wins; 11 reserved, treated like 10
// R6: abort write disarms channels written one; abort reads zero
// R7: unarmed channel never transfers; arm bits read/write, reset zero; a channel disarmed while selected can still get one grant
// R8: single and block modes disarm themselves when count is reached
// R9: writing one to manual request acts as one trigger; zero ignored
// R10: manual request bit clears when its channel is granted memory; an abort write that spares the channel in the grant cycle keeps it set
// R11: first pointer from two bytes, reset zero, locates channel 0 config
// R12: second pointer from two bytes, reset zero, starts channels 1-4 config
// R13: done flag sets on completion, software writes zero to clear
// R14: usb write byte order bit: 0 big endian, 1 little endian
// R15: usb read byte order bit: 0 big endian, 1 little endian
// R16: software writes zero arm bits for channels it keeps during abort
// R17: configs for channels 1-4 fetched from one 32-byte area
// R18: done flag sets regardless of the interrupt enable field
// R19: transfer modes single, block, repeated single, repeated block
// R20: channel n config at second pointer plus eight times n minus one
// R21: equal priority pending channels: lowest number served first
`ifndef DMACC_DEFS_SVH
`define DMACC_DEFS_SVH
`define DMACC_ADR_ENDIAN   8'h95
`define DMACC_ADR_DONE     8'hD1
`define DMACC_ADR_P1L      8'hD2
`define DMACC_ADR_P1H      8'hD3
`define DMACC_ADR_P0L      8'hD4
`define DMACC_ADR_P0H      8'hD5
`define DMACC_ADR_ARM      8'hD6
`define DMACC_ADR_REQ      8'hD7
`define DMACC_ABORT_BIT    7
`define DMACC_USBW_BIT     1
`define DMACC_USBR_BIT     0
`define DMACC_CFG_BYTES    16'h0008
`define DMACC_VARIABLE_LENGTH_MODE_FIXED   3'h0
`define DMACC_VARIABLE_LENGTH_MODE_ALT     3'h7
`define DMACC_PRIO_LOW     2'h0
`define DMACC_PRIO_NORM    2'h1
`define DMACC_TM_SINGLE    2'h0
`define DMACC_TM_BLOCK     2'h1
`define DMACC_TM_RSINGLE   2'h2
`define DMACC_LEN7_MASK    13'h007F
`define DMACC_LEN8_MASK    13'h00FF
`endif

// File: logic/dmacc_pkg.sv
// types shared by the dma channel control block
package dmacc_pkg;
   typedef enum logic [1:0] {DMACC_TM_SGL, DMACC_TM_BLK,
                             DMACC_TM_RSGL, DMACC_TM_RBLK} dmacc_transfer_mode_e;
   typedef enum logic [1:0] {DMACC_IDLE, DMACC_XFER} dmacc_state_e;
endpackage : dmacc_pkg

// File: logic/dmacc_arbiter.sv
// cpu against dma memory arbiter with per-priority policy
`timescale 1ns/100ps
`include "dmacc_defs.svh"
module dmacc_arbiter (
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   // requests
   input  wire logic       dma_req_i,
   input  wire logic [1:0] prio_i,
   input  wire logic       cpu_req_i,
   // outcome
   output logic            dma_win_o
);
   typedef struct packed {
      logic lost;
   } dmacc_arb_s;
   dmacc_arb_s st, next_st;
   logic win;

   always_comb begin
      next_st = st;
      if (!cpu_req_i)
         win = dma_req_i;
      else if (prio_i == `DMACC_PRIO_LOW)
         win = 1'b0;                                  // [R3]
      else if (prio_i == `DMACC_PRIO_NORM)
         win = dma_req_i && st.lost;                  // [R4]
      else
         win = dma_req_i;                             // [R5]
      if (dma_req_i)
         next_st.lost = !win;
      dma_win_o = win;
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i)
         st <= '0;
      else
         st <= next_st;
   end

   a_norm_alternate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (dma_req_i && cpu_req_i && prio_i == `DMACC_PRIO_NORM && !dma_win_o)
      ##1 (dma_req_i && cpu_req_i && prio_i == `DMACC_PRIO_NORM)
      |-> dma_win_o) else $error("normal dma lost twice"); // [R4]
   a_low_defers: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (cpu_req_i && prio_i == `DMACC_PRIO_LOW) |-> !dma_win_o)
      else $error("low dma beat cpu"); // [R3]
   a_high_wins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (dma_req_i && prio_i[1]) |-> dma_win_o)
      else $error("high dma lost"); // [R5]
endmodule : dmacc_arbiter

// File: logic/dmacc_top.sv
// dma channel control: registers, channel selection, arbitration, completion
`timescale 1ns/100ps
`include "dmacc_defs.svh"
module dmacc_top #(
   parameter int NCH = 5
) (
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // special function register port
   input  wire logic [7:0]        sfr_addr_i,
   input  wire logic              sfr_wr_i,
   input  wire logic [7:0]        sfr_wdata_i,
   output logic      [7:0]        sfr_rdata_o,
   // per-channel configuration tail fields, one entry per channel
   input  wire logic [NCH-1:0]    completion_irq_enable_i,
   input  wire logic [NCH-1:0]    eighth_bit_length_mode_i,
   input  wire logic [NCH*3-1:0]  variable_length_mode_i,
   input  wire logic [NCH-1:0]    word_transfer_select_i,
   input  wire logic [NCH*2-1:0]  transfer_mode_i,
   input  wire logic [NCH*2-1:0]  priority_i,
   input  wire logic [NCH*13-1:0] transfer_count_i,
   // triggers and memory side
   input  wire logic [NCH-1:0]    trigger_i,
   input  wire logic              cpu_req_i,
   input  wire logic              mem_done_i,
   input  wire logic [7:0]        length_byte_i,
   input  wire logic              length_valid_i,
   // outputs
   output logic                   dma_grant_o,
   output logic      [2:0]        grant_ch_o,
   output logic      [15:0]       cfg_addr_o,
   output logic      [12:0]       count_limit_o,
   output logic                   irq_req_o,
   output logic                   usb_write_little_endian_o,
   output logic                   usb_read_little_endian_o
);
   initial begin
      if (NCH < 2 || NCH > 8)
         $error("NCH out of range");
   end

   typedef struct packed {
      logic [NCH-1:0]            arm;
      logic [NCH-1:0]            manreq;
      logic [NCH-1:0]            pend;
      logic [NCH-1:0]            done;
      logic [15:0]               ptr0;
      logic [15:0]               ptr1;
      logic [7:0]                endian;
      dmacc_pkg::dmacc_state_e   state;
      logic [2:0]                ch;
      logic [12:0]               cnt;
      logic [12:0]               limit;
      logic                      grant;
      logic                      busy;
      logic [15:0]               cfg_addr;
      logic                      irq;
      logic [7:0]                rdata;
   } dmacc_st_s;
   dmacc_st_s st, next_st;
   logic      dma_win;
   logic      any_ready;
   logic [2:0] pick;

   // config address of channel n
   function automatic logic [15:0] cfg_of(input logic [2:0] n,
                                          input logic [15:0] p0,
                                          input logic [15:0] p1);
      if (n == 3'h0)
         cfg_of = p0;                                          // [R11]
      else
         cfg_of = p1 + 16'(n - 3'h1) * `DMACC_CFG_BYTES;       // [R12] [R17] [R20]
   endfunction : cfg_of

   // best ready channel: highest priority class, lowest index
   always_comb begin
      logic [1:0] best;
      best = 2'h0;
      any_ready = 1'b0;
      pick = 3'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (st.arm[i] && st.pend[i] &&                       // [R7]
             (!any_ready || priority_i[i*2 +: 2] >= best)) begin // [R21]
            any_ready = 1'b1;
            best = priority_i[i*2 +: 2];
            pick = 3'(i);
         end
      end
   end

   dmacc_arbiter u_arb (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .dma_req_i (st.state == dmacc_pkg::DMACC_XFER && !st.busy),
      .prio_i    (priority_i[st.ch*2 +: 2]),
      .cpu_req_i (cpu_req_i),
      .dma_win_o (dma_win)
   );

   always_comb begin
      logic [NCH-1:0] wr_arm;
      logic [12:0]    lim;
      logic [2:0]     vl;
      logic [1:0]     tm;
      logic           fin;
      wr_arm = '0;
      lim = 13'h0000;
      vl = 3'h0;
      tm = 2'h0;
      fin = 1'b0;
      next_st = st;
      next_st.grant = 1'b0;
      next_st.irq = 1'b0;
      // a manual request queues once at its write, not every cycle it stands
      next_st.pend = st.pend | trigger_i;                      // [R9]
      // channel engine
      case (st.state)
         dmacc_pkg::DMACC_IDLE: begin
            if (any_ready) begin
               next_st.state = dmacc_pkg::DMACC_XFER;
               next_st.ch = pick;
               next_st.cnt = 13'h0000;
               next_st.busy = 1'b0;
               next_st.limit = transfer_count_i[pick*13 +: 13];
               next_st.cfg_addr = cfg_of(pick, st.ptr0, st.ptr1);
               next_st.pend[pick] = 1'b0;
            end
         end
         dmacc_pkg::DMACC_XFER: begin
            vl = variable_length_mode_i[st.ch*3 +: 3];
            tm = transfer_mode_i[st.ch*2 +: 2];
            if (length_valid_i && vl != `DMACC_VARIABLE_LENGTH_MODE_FIXED &&
                vl != `DMACC_VARIABLE_LENGTH_MODE_ALT && !word_transfer_select_i[st.ch]) begin
               lim = eighth_bit_length_mode_i[st.ch] ?
                     ({5'h00, length_byte_i} & `DMACC_LEN7_MASK) :
                     ({5'h00, length_byte_i} & `DMACC_LEN8_MASK);  // [R2]
               if (lim < st.limit)
                  next_st.limit = lim;
            end
            // one grant per unit: no new request until memory answers
            if (dma_win) begin
               next_st.grant = 1'b1;
               next_st.busy = 1'b1;
               next_st.manreq[st.ch] = 1'b0;                   // [R10]
            end
            if (mem_done_i) begin
               next_st.busy = 1'b0;
               next_st.cnt = st.cnt + 13'h0001;
               // block modes run on, single modes stop per trigger
               fin = (st.cnt + 13'h0001 >= st.limit);
               if (fin || tm == `DMACC_TM_SINGLE || tm == `DMACC_TM_RSINGLE)
                  next_st.state = dmacc_pkg::DMACC_IDLE;
               if (fin) begin
                  next_st.done[st.ch] = 1'b1;                  // [R13] [R18]
                  next_st.irq = completion_irq_enable_i[st.ch]; // [R1]
                  if (!tm[1])
                     next_st.arm[st.ch] = 1'b0;                // [R8] [R19]
               end
            end
            if (!st.arm[st.ch])
               next_st.state = dmacc_pkg::DMACC_IDLE;          // [R6]
         end
         default: next_st.state = dmacc_pkg::DMACC_IDLE;
      endcase
      // register writes
      if (sfr_wr_i) begin
         case (sfr_addr_i)
            `DMACC_ADR_ENDIAN: next_st.endian = sfr_wdata_i;   // [R14] [R15]
            `DMACC_ADR_DONE:
               // write zero clears; a completion this cycle still wins unless its flag was already set
               next_st.done = (st.done & sfr_wdata_i[NCH-1:0]) |
                              (next_st.done & ~st.done);       // [R13]
            `DMACC_ADR_P1L: next_st.ptr1[7:0] = sfr_wdata_i;   // [R12]
            `DMACC_ADR_P1H: next_st.ptr1[15:8] = sfr_wdata_i;
            `DMACC_ADR_P0L: next_st.ptr0[7:0] = sfr_wdata_i;   // [R11]
            `DMACC_ADR_P0H: next_st.ptr0[15:8] = sfr_wdata_i;
            `DMACC_ADR_ARM: begin
               wr_arm = sfr_wdata_i[NCH-1:0];
               if (sfr_wdata_i[`DMACC_ABORT_BIT]) begin
                  // software keeps others by writing zero to them
                  next_st.arm = next_st.arm & ~wr_arm;         // [R6] [R16]
                  next_st.pend = next_st.pend & ~wr_arm;
                  next_st.manreq = st.manreq & ~wr_arm;
                  if (wr_arm[st.ch])
                     next_st.state = dmacc_pkg::DMACC_IDLE;
               end else
                  next_st.arm = wr_arm;                        // [R7]
            end
            `DMACC_ADR_REQ: begin
               next_st.manreq = next_st.manreq | sfr_wdata_i[NCH-1:0]; // [R9]
               next_st.pend = next_st.pend | sfr_wdata_i[NCH-1:0];     // [R9]
            end
            default: ;
         endcase
      end
      // read data, registered
      case (sfr_addr_i)
         `DMACC_ADR_ENDIAN: next_st.rdata = st.endian;
         `DMACC_ADR_DONE:   next_st.rdata = 8'(st.done);
         `DMACC_ADR_P1L:    next_st.rdata = st.ptr1[7:0];
         `DMACC_ADR_P1H:    next_st.rdata = st.ptr1[15:8];
         `DMACC_ADR_P0L:    next_st.rdata = st.ptr0[7:0];
         `DMACC_ADR_P0H:    next_st.rdata = st.ptr0[15:8];
         `DMACC_ADR_ARM:    next_st.rdata = 8'(st.arm);       // [R6]
         `DMACC_ADR_REQ:    next_st.rdata = 8'(st.manreq);
         default:           next_st.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign sfr_rdata_o = st.rdata;
   assign dma_grant_o = st.grant;
   assign grant_ch_o = st.ch;
   assign cfg_addr_o = st.cfg_addr;
   assign count_limit_o = st.limit;
   assign irq_req_o = st.irq;
   assign usb_write_little_endian_o = st.endian[`DMACC_USBW_BIT]; // [R14]
   assign usb_read_little_endian_o = st.endian[`DMACC_USBR_BIT];  // [R15]

   sequence s_abort_write;
      sfr_wr_i && sfr_addr_i == `DMACC_ADR_ARM &&
      sfr_wdata_i[`DMACC_ABORT_BIT];
   endsequence
   a_abort_disarm: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_abort_write |=> ((st.arm & $past(sfr_wdata_i[NCH-1:0])) == '0))
      else $error("abort left channel armed"); // [R6]
   a_grant_armed: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st.state == dmacc_pkg::DMACC_IDLE && any_ready) |-> st.arm[pick])
      else $error("unarmed channel picked"); // [R7]
   a_grant_clrreq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (dma_win && !(sfr_wr_i && sfr_addr_i == `DMACC_ADR_REQ))
      |=> !st.manreq[$past(st.ch)]) else $error("request not cleared"); // [R10]
   a_done_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      irq_req_o |-> st.done[st.ch]) else $error("irq without done"); // [R1]
   a_ptr0_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st.state == dmacc_pkg::DMACC_IDLE && any_ready && pick == 3'h0)
      |=> cfg_addr_o == $past(st.ptr0)) else $error("bad ch0 cfg"); // [R11]
   a_abort_reads0: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(sfr_addr_i == `DMACC_ADR_ARM) |-> !sfr_rdata_o[7])
      else $error("abort read one"); // [R6]
   a_usbw_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (sfr_wr_i && sfr_addr_i == `DMACC_ADR_ENDIAN) |=>
      usb_write_little_endian_o == $past(sfr_wdata_i[1]))
      else $error("usb write order"); // [R14]
   a_usbr_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (sfr_wr_i && sfr_addr_i == `DMACC_ADR_ENDIAN) |=>
      usb_read_little_endian_o == $past(sfr_wdata_i[0]))
      else $error("usb read order"); // [R15]
endmodule : dmacc_top

// File: sim/dmacc_mem_model.sv
// memory side partner: answers each dma grant with one finished unit
`timescale 1ns/100ps
module dmacc_mem_model (
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   // bus side
   input  wire logic       grant_i,
   input  wire logic [1:0] lat_i,
   output logic            mem_done_o
);
   logic       busy;
   logic [1:0] cnt;
   // latency varies per unit so prompt and slow answers both occur
   always_ff @(posedge clk_sys_i) begin
      mem_done_o <= 1'b0;
      if (rst_i) begin
         busy <= 1'b0;
         cnt  <= 2'h0;
      end else if (grant_i) begin
         busy <= 1'b1;
         cnt  <= lat_i;
      end else if (busy && cnt == 2'h0) begin
         busy       <= 1'b0;
         mem_done_o <= 1'b1;
      end else if (busy) begin
         cnt <= cnt - 2'h1;
      end
   end
endmodule : dmacc_mem_model

// File: sim/test_dma_channel_control.sv
// self-checking bench for the dma channel control block
`timescale 1ns/100ps
`include "dmacc_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_dma_channel_control;
   logic        clk_sys_i, rst_i, sfr_wr_i, cpu_req_i, mem_done_i, rd_req;
   logic        rd_d1, dma_grant_o, irq_req_o, wle, rle;
   logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, re, e;
   logic [4:0]  ien_v, m8_v, ws_v, trigger_i;
   logic [9:0]  tm_v, pr_v;
   logic [2:0]  grant_ch_o, gch;
   logic [15:0] cfg_addr_o, p0, p1, ga;
   logic [12:0] count_limit_o;
   logic [1:0]  lat;
   logic [7:0]  exp_q[$];
   logic [2:0]  gq[$];
   logic [15:0] aq[$];
   int          errors, n_compared, irq_n;
   dmacc_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .completion_irq_enable_i(ien_v), .eighth_bit_length_mode_i(m8_v),
      .variable_length_mode_i(15'h0000), .word_transfer_select_i(ws_v),
      .transfer_mode_i(tm_v), .priority_i(pr_v),
      .transfer_count_i({5{13'h0001}}), .trigger_i(trigger_i),
      .cpu_req_i(cpu_req_i), .mem_done_i(mem_done_i),
      .length_byte_i(8'h00), .length_valid_i(1'b0),
      .dma_grant_o(dma_grant_o), .grant_ch_o(grant_ch_o),
      .cfg_addr_o(cfg_addr_o), .count_limit_o(count_limit_o),
      .irq_req_o(irq_req_o), .usb_write_little_endian_o(wle),
      .usb_read_little_endian_o(rle));
   dmacc_mem_model i_mem (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .grant_i(dma_grant_o), .lat_i(lat), .mem_done_o(mem_done_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   // watcher: read data lands one cycle after the address is taken
   always @(posedge clk_sys_i) begin
      rd_d1 <= rd_req;
      lat   <= 2'($urandom_range(3, 0));
      if (rd_d1 && exp_q.size() > 0) begin
         re = exp_q.pop_front();
         `CHK(sfr_rdata_o, re)
      end
      if (!rst_i && dma_grant_o === 1'b1) begin
         gq.push_back(grant_ch_o);
         aq.push_back(cfg_addr_o);
      end
      if (!rst_i && irq_req_o === 1'b1) irq_n++;
   end
   task give_verdict();
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      sfr_wr_i <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_sys_i);
      sfr_addr_i <= a;
      rd_req     <= 1'b1;
      exp_q.push_back(x);
      @(posedge clk_sys_i);
      rd_req <= 1'b0;
   endtask : rd
   task wait_grant(input logic want);
      int i;
      i = 0;
      while (gq.size() == 0 && i < 60) begin
         @(posedge clk_sys_i);
         i++;
      end
      `CHK(gq.size() > 0, want)
      if (want && gq.size() == 0) give_verdict();
   endtask : wait_grant
   task pop_grant(input logic [2:0] ch, input logic [15:0] ea);
      gch = gq.pop_front();
      ga  = aq.pop_front();
      `CHK(gch, ch)
      `CHK(ga, ea)
   endtask : pop_grant
   task run_ch(input int ch, input logic [1:0] mode, input logic ien);
      logic [7:0] m;
      int         i0;
      m  = 8'h01 << ch;
      i0 = irq_n;
      tm_v[ch*2 +: 2] <= mode;
      pr_v[ch*2 +: 2] <= 2'h2;
      ien_v[ch]       <= ien;
      cpu_req_i       <= 1'($urandom_range(1, 0));
      wr(`DMACC_ADR_ARM, m);
      if (ch == 0) begin
         trigger_i <= m[4:0];
         @(posedge clk_sys_i);
         trigger_i <= 5'h00;
      end else
         wr(`DMACC_ADR_REQ, m);
      wait_grant(1'b1);
      pop_grant(3'(ch), ch == 0 ? p0 : p1 + 16'(8 * (ch - 1)));
      repeat (10) @(posedge clk_sys_i);
      `CHK(irq_n - i0, int'(ien))
      rd(`DMACC_ADR_DONE, m);
      rd(`DMACC_ADR_REQ, 8'h00);
      rd(`DMACC_ADR_ARM, mode[1] ? m : 8'h00);
      wr(`DMACC_ADR_DONE, 8'h00);
      rd(`DMACC_ADR_DONE, 8'h00);
      wr(`DMACC_ADR_ARM, 8'h80 | m);
      rd(`DMACC_ADR_ARM, 8'h00);
   endtask : run_ch
   initial begin
      rst_i = 1'b1;
      {sfr_wr_i, cpu_req_i, rd_req, rd_d1, trigger_i} = '0;
      {sfr_addr_i, sfr_wdata_i, ien_v, tm_v, pr_v} = '0;
      errors = 0;
      n_compared = 0;
      irq_n = 0;
      void'($urandom(32'h75FDEEA5));
      m8_v = 5'($urandom);
      ws_v = 5'($urandom);
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      for (int a = 8'hD1; a <= 8'hD7; a++) rd(8'(a), 8'h00);
      rd(`DMACC_ADR_ENDIAN, 8'h00);
      rd(8'h00, 8'h00);
      p0 = 16'($urandom);
      p1 = 16'($urandom);
      wr(`DMACC_ADR_P0L, p0[7:0]);
      wr(`DMACC_ADR_P0H, p0[15:8]);
      wr(`DMACC_ADR_P1H, p1[15:8]);
      wr(`DMACC_ADR_P1L, p1[7:0]);
      rd(`DMACC_ADR_P0H, p0[15:8]);
      rd(`DMACC_ADR_P1L, p1[7:0]);
      e = 8'($urandom);
      wr(`DMACC_ADR_ENDIAN, e);
      rd(`DMACC_ADR_ENDIAN, e);
      `CHK(wle, e[1])
      `CHK(rle, e[0])
      for (int c = 0; c < 5; c++) run_ch(c, 2'(c), 1'(c));
      // two equal-priority channels pending at once
      tm_v <= {5{2'h1}};
      wr(`DMACC_ADR_ARM, 8'h0A);
      wr(`DMACC_ADR_REQ, 8'h0A);
      wait_grant(1'b1);
      pop_grant(3'h1, p1);
      wait_grant(1'b1);
      pop_grant(3'h3, p1 + 16'h0010);
      repeat (10) @(posedge clk_sys_i);
      rd(`DMACC_ADR_DONE, 8'h0A);
      wr(`DMACC_ADR_DONE, 8'h00);
      // low priority waits for the cpu, normal wins anyway
      pr_v[5:4] <= 2'h0;
      cpu_req_i <= 1'b1;
      wr(`DMACC_ADR_ARM, 8'h04);
      wr(`DMACC_ADR_REQ, 8'h04);
      wait_grant(1'b0);
      cpu_req_i <= 1'b0;
      wait_grant(1'b1);
      pop_grant(3'h2, p1 + 16'h0008);
      repeat (10) @(posedge clk_sys_i);
      pr_v[5:4] <= 2'h1;
      cpu_req_i <= 1'b1;
      wr(`DMACC_ADR_ARM, 8'h04);
      wr(`DMACC_ADR_REQ, 8'h04);
      wait_grant(1'b1);
      pop_grant(3'h2, p1 + 16'h0008);
      cpu_req_i <= 1'b0;
      // a request on an unarmed channel must stay idle
      wr(`DMACC_ADR_REQ, 8'h10);
      wait_grant(1'b0);
      give_verdict();
   end
endmodule : test_dma_channel_control
